// >>> fault_latch_pkg.sv
// constants, types and helpers shared by the fault latch block
`default_nettype none
package fault_latch_pkg;
    // ****************************************
    // register port widths
    // ****************************************
    localparam int AW = 8;
    localparam int DW = 8;
    typedef logic [AW-1:0] addr_t;
    typedef logic [DW-1:0] reg8_t;
    // ****************************************
    // register offsets
    // ****************************************
    localparam addr_t ADDR_SYS_MASK = 8'h2f;
    localparam addr_t ADDR_UPPER_MASK = 8'h33;
    localparam addr_t ADDR_SYS_LATCH = 8'h34;
    localparam addr_t ADDR_SUMMARY = 8'h35;
    localparam addr_t ADDR_CH1_LATCH = 8'h36;
    // ****************************************
    // reset values and writable bits
    // ****************************************
    localparam reg8_t RST_SYS_MASK = 8'hf8;
    localparam reg8_t RST_UPPER_MASK = 8'h30;
    localparam reg8_t RST_ZERO = 8'h00;
    localparam reg8_t WMASK_SYS = 8'hf8;
    localparam reg8_t WMASK_UPPER = 8'hff;
    // ****************************************
    // group widths and field positions
    // ****************************************
    localparam int SYS_N = 5;
    localparam int UPPER_N = 8;
    localparam int CH1_N = 8;
    localparam int MISC_N = 2;
    localparam int SYS_LSB = 3;
    localparam int SUM_CH1 = 7;
    localparam int SUM_CH2 = 6;
    localparam int SUM_VBAT = 3;
    localparam int MISC_CH2 = 1;
    localparam int MISC_VBAT = 0;
    // ****************************************
    // register access sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b01,
        ACC_RESP = 2'b10
    } acc_state_e;
    // address match of one register access
    function automatic logic hit(input addr_t a, input addr_t off, input logic strobe);
        hit = strobe && (a == off);
    endfunction
    // any unmasked pending bit in a group
    function automatic logic pend(input reg8_t lat, input reg8_t mask);
        pend = |(lat & ~mask);
    endfunction
endpackage
`default_nettype wire

// >>> fault_path_if.sv
// event path between synchroniser, latch bank and register logic
`default_nettype none
interface fault_path_if #(parameter int W = 8);
    logic [W-1:0] raw;
    logic [W-1:0] evt;
    logic [W-1:0] clr;
    logic [W-1:0] lat;
    modport syncer (input raw, output evt);
    modport bank (input evt, input clr, output lat);
    modport ctrl (output raw, output clr, input evt, input lat);
endinterface
`default_nettype wire

// >>> fault_sync.sv
// three-stage input synchroniser with agreement filter
`default_nettype none
module fault_sync #(parameter int W = 8) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // event path
    fault_path_if.syncer p
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;
    logic [W-1:0] nxt_out;

    // a bit changes only while stages two and three agree
    always_comb begin
        nxt_out = (s3_ff & ~(s2_ff ^ s3_ff)) | (out_ff & (s2_ff ^ s3_ff));
    end

    // synchroniser chain; first stage feeds only the second
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            out_ff <= '0;
        end else if (ce) begin
            s1_ff <= p.raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
        end
    end

    assign p.evt = out_ff;
endmodule
`default_nettype wire

// >>> fault_latch_bank.sv
// sticky event latches cleared by strobe, set wins over clear
`default_nettype none
module fault_latch_bank #(parameter int W = 8) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // event path
    fault_path_if.bank p
);
    logic [W-1:0] lat_ff;

    // capture events, drop only cleared bits whose event is gone
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lat_ff <= '0;
        end else if (ce) begin
            lat_ff <= p.evt | (lat_ff & ~p.clr); // [RULE_22]
        end
    end

    assign p.lat = lat_ff;
endmodule
`default_nettype wire

// >>> fault_interrupt_mask_latch.sv
// fault mask and latched fault status registers with interrupt output
// Functional notes
// [RULE_01] mask bit 7 gates the analog monitor upper threshold fault, reset 0
// [RULE_02] mask bit 6 gates the analog monitor lower threshold fault, reset 0
// [RULE_03] mask bit 5 gates voice activity power-up event, reset 1
// [RULE_04] mask bit 4 gates voice activity power-down event, reset 1
// [RULE_05] mask bits 3 and 2 gate bias short and bias high current, reset 0
// [RULE_06] mask bits 1 and 0 gate bias low current and bias overvoltage, reset 0
// [RULE_07] upper mask register at 0x33, reads 0x30 after reset
// [RULE_08] system latch bit 7 records clock error, read only, clears on read
// [RULE_09] system latch bit 6 records PLL lock, clears on read, reset 0
// [RULE_10] system latch bits 5..3 record boost temp, current, monitor events
// [RULE_11] system latch register at 0x34, resets to 0x00
// [RULE_12] summary bit 7 shows any channel one fault
// [RULE_13] summary bit 6 shows any channel two fault
// [RULE_14] summary bit 3 shows battery short while battery below bias
// [RULE_15] channel one latch bit 7 flags open inputs, clears on read
// [RULE_16] channel one latch bit 6 flags inputs shorted together
// [RULE_17] channel one bits 5 and 4 flag positive, negative input shorted to ground
// [RULE_18] channel one bits 3 and 2 flag inputs shorted to bias
// [RULE_19] channel one bits 1 and 0 flag inputs shorted to battery
// [RULE_20] reserved bits read zero; host writes only their reset value
// [RULE_21] system mask bit 7 at 0x2F masks clock error, reset 1
// [RULE_22] latched bit holds until read, stays set if event still present
// [RULE_23] masked events never raise interrupt but still latch
// [RULE_24] summary bit is OR of that channel's latch bits
`default_nettype none
module fault_interrupt_mask_latch
    import fault_latch_pkg::*;
(
    // clock, reset and clock enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // register port
    input wire fault_latch_pkg::addr_t reg_addr,
    input wire logic reg_wr,
    input wire fault_latch_pkg::reg8_t reg_wdata,
    input wire logic reg_rd,
    output logic [fault_latch_pkg::DW-1:0] reg_rdata,
    output logic reg_rvalid,
    // fault detector inputs from the analog side
    input wire logic [fault_latch_pkg::SYS_N-1:0] sys_event_raw,
    input wire logic [fault_latch_pkg::UPPER_N-1:0] upper_event_raw,
    input wire logic [fault_latch_pkg::CH1_N-1:0] ch1_fault_raw,
    input wire logic ch2_fault_any_raw,
    input wire logic vbat_low_short_raw,
    // mask levels and clear from neighbouring register logic
    input wire logic ch1_fault_mask,
    input wire logic vbat_short_mask,
    input wire logic upper_latch_clear,
    // status and control outputs
    output logic [fault_latch_pkg::UPPER_N-1:0] upper_event_latched,
    output logic [fault_latch_pkg::DW-1:0] sys_mask_out,
    output logic [fault_latch_pkg::DW-1:0] upper_mask_out,
    output logic irq
);

    // ****************************************
    // declarations
    // ****************************************
    reg8_t sys_mask_ff;
    reg8_t upper_mask_ff;
    reg8_t rdata_ff;
    reg8_t nxt_rdata;
    reg8_t sys_latch_word;
    reg8_t summary_word;
    reg8_t ch1_latch_word;
    reg8_t sys_mask_word;
    reg8_t upper_pad;
    reg8_t ch1_pad;
    acc_state_e acc_ff;
    acc_state_e nxt_acc;
    logic irq_ff;
    logic nxt_irq;
    logic sys_pending;
    logic upper_pending;
    logic ch1_pending;
    logic vbat_pending;
    logic wr_sys_mask;
    logic wr_upper_mask;
    logic rd_sys_latch;
    logic rd_summary;
    logic rd_ch1_latch;
    logic rd_sys_mask;
    logic rd_upper_mask;
    logic rd_take;
    logic wr_take;

    // ****************************************
    // event paths: one per group of inputs
    // ****************************************
    fault_path_if #(.W(SYS_N)) sys_p ();
    fault_path_if #(.W(UPPER_N)) upper_p ();
    fault_path_if #(.W(CH1_N)) ch1_p ();
    fault_path_if #(.W(MISC_N)) misc_p ();

    // raw detector levels into the synchronisers
    assign sys_p.raw = sys_event_raw;
    assign upper_p.raw = upper_event_raw;
    assign ch1_p.raw = ch1_fault_raw;
    assign misc_p.raw = {ch2_fault_any_raw, vbat_low_short_raw};

    // ****************************************
    // synchronisers
    // ****************************************
    fault_sync #(.W(SYS_N)) u_sys_sync (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .p(sys_p.syncer)
    );
    fault_sync #(.W(UPPER_N)) u_upper_sync (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .p(upper_p.syncer)
    );
    fault_sync #(.W(CH1_N)) u_ch1_sync (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .p(ch1_p.syncer)
    );
    fault_sync #(.W(MISC_N)) u_misc_sync (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .p(misc_p.syncer)
    );

    // ****************************************
    // latch banks
    // ****************************************
    fault_latch_bank #(.W(SYS_N)) u_sys_bank (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .p(sys_p.bank)
    );
    fault_latch_bank #(.W(UPPER_N)) u_upper_bank (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .p(upper_p.bank)
    );
    fault_latch_bank #(.W(CH1_N)) u_ch1_bank (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .p(ch1_p.bank)
    );
    fault_latch_bank #(.W(MISC_N)) u_misc_bank (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .p(misc_p.bank)
    );

    // ****************************************
    // access decode
    // ****************************************

    // accesses count only while the clock enable is high
    assign rd_take = reg_rd && ce;
    assign wr_take = reg_wr && ce;

    // write strobes for the two mask registers
    assign wr_sys_mask = hit(reg_addr, ADDR_SYS_MASK, wr_take);
    assign wr_upper_mask = hit(reg_addr, ADDR_UPPER_MASK, wr_take); // [RULE_07]

    // read strobes, one per mapped register
    assign rd_sys_mask = hit(reg_addr, ADDR_SYS_MASK, rd_take);
    assign rd_upper_mask = hit(reg_addr, ADDR_UPPER_MASK, rd_take);
    assign rd_sys_latch = hit(reg_addr, ADDR_SYS_LATCH, rd_take); // [RULE_11]
    assign rd_summary = hit(reg_addr, ADDR_SUMMARY, rd_take);
    assign rd_ch1_latch = hit(reg_addr, ADDR_CH1_LATCH, rd_take);

    // ****************************************
    // read-clear strobes into the latch banks
    // ****************************************

    // reading the system latch register clears all five bits
    assign sys_p.clr = {SYS_N{rd_sys_latch}}; // [RULE_08] [RULE_09] [RULE_10]

    // upper events are owned by another register; cleared by its strobe
    assign upper_p.clr = {UPPER_N{upper_latch_clear}};

    // reading channel one latch clears every diagnostic bit
    assign ch1_p.clr = {CH1_N{rd_ch1_latch}}; // [RULE_15] [RULE_16] [RULE_17] [RULE_18] [RULE_19]

    // channel two bit follows its level; battery short holds until summary read
    assign misc_p.clr = {1'b1, rd_summary}; // [RULE_13] [RULE_14]

    // ****************************************
    // mask registers
    // ****************************************

    // system event mask; reserved low bits never store
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sys_mask_ff <= RST_SYS_MASK; // [RULE_21]
        end else if (wr_sys_mask) begin
            sys_mask_ff <= reg_wdata & WMASK_SYS; // [RULE_20]
        end
    end

    // upper fault mask; all eight bits writable
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            upper_mask_ff <= RST_UPPER_MASK; // [RULE_01] [RULE_02] [RULE_03] [RULE_04] [RULE_05] [RULE_06]
        end else if (wr_upper_mask) begin
            upper_mask_ff <= reg_wdata & WMASK_UPPER; // [RULE_07]
        end
    end

    // ****************************************
    // readback words
    // ****************************************

    // widen narrow groups to register width
    assign upper_pad = reg8_t'(upper_p.lat);
    assign ch1_pad = reg8_t'(ch1_p.lat);

    // system latch bits sit at 7..3, reserved bits read zero
    assign sys_latch_word = reg8_t'({sys_p.lat, {SYS_LSB{1'b0}}}); // [RULE_20]

    // system mask word, same layout
    assign sys_mask_word = sys_mask_ff & WMASK_SYS;

    // channel one latch word maps bit for bit
    assign ch1_latch_word = ch1_pad;

    // summary word: channel OR, channel two level, battery short latch
    always_comb begin
        summary_word = RST_ZERO;
        summary_word[SUM_CH1] = |ch1_p.lat; // [RULE_12] [RULE_24]
        summary_word[SUM_CH2] = misc_p.lat[MISC_CH2]; // [RULE_13] [RULE_24]
        summary_word[SUM_VBAT] = misc_p.lat[MISC_VBAT]; // [RULE_14]
    end

    // ****************************************
    // read data mux
    // ****************************************

    // unmapped addresses read zero
    always_comb begin
        nxt_rdata = RST_ZERO;
        if (rd_sys_mask) begin
            nxt_rdata = sys_mask_word;
        end else if (rd_upper_mask) begin
            nxt_rdata = upper_mask_ff; // [RULE_07]
        end else if (rd_sys_latch) begin
            nxt_rdata = sys_latch_word; // [RULE_08]
        end else if (rd_summary) begin
            nxt_rdata = summary_word;
        end else if (rd_ch1_latch) begin
            nxt_rdata = ch1_latch_word;
        end
    end

    // read data register; holds until the next read
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_ff <= RST_ZERO;
        end else if (rd_take) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ****************************************
    // access sequencer
    // ****************************************

    // response state lasts one cycle after each taken read
    always_comb begin
        nxt_acc = acc_ff;
        unique case (acc_ff)
            ACC_IDLE: begin
                if (rd_take) begin
                    nxt_acc = ACC_RESP;
                end
            end
            ACC_RESP: begin
                if (!rd_take) begin
                    nxt_acc = ACC_IDLE;
                end
            end
            default: begin
                nxt_acc = ACC_IDLE;
            end
        endcase
    end

    // sequencer state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acc_ff <= ACC_IDLE;
        end else if (ce) begin
            acc_ff <= nxt_acc;
        end
    end

    // ****************************************
    // interrupt
    // ****************************************

    // system group, masked bit for bit by the system mask
    assign sys_pending = pend(sys_latch_word, sys_mask_word); // [RULE_21] [RULE_23]

    // upper group, masked bit for bit by the upper mask
    assign upper_pending = pend(upper_pad, upper_mask_ff); // [RULE_23]

    // channel one masked as a whole by its level input
    assign ch1_pending = (|ch1_p.lat) & ~ch1_fault_mask; // [RULE_23]

    // battery short masked by its own level input
    assign vbat_pending = misc_p.lat[MISC_VBAT] & ~vbat_short_mask; // [RULE_23]

    // any unmasked latched event except the channel two bit raises the interrupt
    always_comb begin
        nxt_irq = sys_pending | upper_pending | ch1_pending | vbat_pending;
    end

    // registered interrupt level
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else if (ce) begin
            irq_ff <= nxt_irq;
        end
    end

    // ****************************************
    // outputs
    // ****************************************

    // read answer from the data flop and sequencer state
    assign reg_rdata = rdata_ff;
    assign reg_rvalid = (acc_ff == ACC_RESP);

    // latch, mask and interrupt state for the neighbours
    assign upper_event_latched = upper_p.lat;
    assign sys_mask_out = sys_mask_ff;
    assign upper_mask_out = upper_mask_ff;
    assign irq = irq_ff;

endmodule
`default_nettype wire

// >>> host_port_model.sv
// host model that drives read and write cycles on the register port
`default_nettype none
module host_port_model
    import fault_latch_pkg::*;
(
    // clock
    input wire logic mclk,
    // register port
    output var fault_latch_pkg::addr_t reg_addr,
    output var fault_latch_pkg::reg8_t reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [fault_latch_pkg::DW-1:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one write strobe, then address and data show a changed pattern
    task automatic wr(input addr_t a, input reg8_t d);
        @(negedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(negedge mclk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // one read strobe, answer awaited for a few cycles only
    task automatic rd(input addr_t a, output reg8_t d, output bit ok);
        int n;
        @(negedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(negedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        ok = 1'b0;
        n = 0;
        while (!ok && n < 4) begin
            if (reg_rvalid === 1'b1) ok = 1'b1;
            else begin
                @(negedge mclk);
                n++;
            end
        end
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// >>> fault_mask_sva.sv
// assertions on the fault mask and latch ports
`default_nettype none
module fault_mask_checker
    import fault_latch_pkg::*;
(
    // clock and control
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // register port
    input wire fault_latch_pkg::addr_t reg_addr,
    input wire logic reg_wr,
    input wire fault_latch_pkg::reg8_t reg_wdata,
    input wire logic reg_rd,
    input wire logic [fault_latch_pkg::DW-1:0] reg_rdata,
    // latch and mask state
    input wire logic upper_latch_clear,
    input wire logic [fault_latch_pkg::UPPER_N-1:0] upper_event_latched,
    input wire logic [fault_latch_pkg::DW-1:0] sys_mask_out,
    input wire logic [fault_latch_pkg::DW-1:0] upper_mask_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // masks leave reset at their defaults
    upper_rst_a: assert property ($fell(rst) |-> upper_mask_out == 8'h30)
        else $error("upper mask reset value wrong");
    sys_rst_a: assert property ($fell(rst) |-> sys_mask_out == 8'hf8)
        else $error("system mask reset value wrong");
    // writes land one cycle later, reserved bits dropped
    upper_write_a: assert property (ce && reg_wr && reg_addr == 8'h33
        |=> upper_mask_out == $past(reg_wdata))
        else $error("upper mask write lost");
    sys_write_a: assert property (ce && reg_wr && reg_addr == 8'h2f
        |=> sys_mask_out == ($past(reg_wdata) & 8'hf8))
        else $error("system mask write wrong");
    mask_hold_a: assert property (!(ce && reg_wr && reg_addr == 8'h33) |=> $stable(upper_mask_out))
        else $error("upper mask changed without write");
    sys_resv_a: assert property (sys_mask_out[2:0] == 3'b000)
        else $error("system mask reserved bits set");
    // read data tied to the addressed register
    upper_read_a: assert property (ce && reg_rd && reg_addr == 8'h33 |=> reg_rdata == $past(upper_mask_out))
        else $error("upper mask read wrong");
    unmapped_read_a: assert property (ce && reg_rd && !(reg_addr inside {8'h2f, 8'h33, 8'h34, 8'h35, 8'h36})
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    latch_resv_a: assert property (ce && reg_rd && reg_addr == 8'h34 |=> reg_rdata[2:0] == 3'b000)
        else $error("system latch reserved bits set");
    sum_resv_a: assert property (ce && reg_rd && reg_addr == 8'h35 |=> (reg_rdata & 8'h37) == 8'h00)
        else $error("summary reserved bits set");
    // latched bits only fall after a clear
    upper_sticky_a: assert property (!upper_latch_clear && !$past(upper_latch_clear)
        |=> (upper_event_latched & $past(upper_event_latched)) == $past(upper_event_latched))
        else $error("upper latch fell without clear");
    cover property (ce && reg_wr && reg_addr == 8'h33);
    cover property (ce && reg_rd && reg_addr == 8'h34);
    cover property ($fell(|upper_event_latched));
endmodule
bind fault_interrupt_mask_latch fault_mask_checker chk (
    .mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .upper_latch_clear(upper_latch_clear),
    .upper_event_latched(upper_event_latched), .sys_mask_out(sys_mask_out), .upper_mask_out(upper_mask_out)
);
`default_nettype wire

// >>> tb_fault_interrupt_mask_latch.sv
// self-checking bench for the fault mask and latch registers
`default_nettype none
module tb_fault_interrupt_mask_latch
    import fault_latch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst, ce, reg_wr, reg_rd, reg_rvalid, irq;
    addr_t reg_addr;
    reg8_t reg_wdata, d, e, got;
    logic [DW-1:0] reg_rdata, sys_mask_out, upper_mask_out;
    logic [SYS_N-1:0] sys_event_raw;
    logic [UPPER_N-1:0] upper_event_raw, upper_event_latched;
    logic [CH1_N-1:0] ch1_fault_raw;
    logic ch2_fault_any_raw, vbat_low_short_raw, ch1_fault_mask, vbat_short_mask, upper_latch_clear;
    int n_errors = 0;
    int n_tests = 0;
    bit ok;
    // behavioural model: expected mask contents by address
    reg8_t mdl[int];
    host_port_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    fault_interrupt_mask_latch uut (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sys_event_raw(sys_event_raw), .upper_event_raw(upper_event_raw), .ch1_fault_raw(ch1_fault_raw),
        .ch2_fault_any_raw(ch2_fault_any_raw), .vbat_low_short_raw(vbat_low_short_raw),
        .ch1_fault_mask(ch1_fault_mask), .vbat_short_mask(vbat_short_mask),
        .upper_latch_clear(upper_latch_clear), .upper_event_latched(upper_event_latched),
        .sys_mask_out(sys_mask_out), .upper_mask_out(upper_mask_out), .irq(irq));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // ****************************************
    // compare and report
    // ****************************************
    task automatic results();
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk_reg(input reg8_t g, input reg8_t x, input string what);
        n_tests++;
        if (g !== x) begin
            n_errors++;
            $display("wrong value at %0t: %s is %h not %h", $time, what, g, x);
        end
    endtask
    task automatic chk_bit(input logic g, input logic x, input string what);
        n_tests++;
        if (g !== x) begin
            n_errors++;
            $display("wrong value at %0t: %s is %b", $time, what, g);
        end
    endtask
    task automatic rd_chk(input addr_t a, input reg8_t x);
        host.rd(a, got, ok);
        if (!ok) begin
            n_errors++;
            $display("wrong value at %0t: read not answered", $time);
            results();
        end
        chk_reg(got, x, "read data");
    endtask
    // host write that keeps the mask model in step; ignored while ce is low
    task automatic wr_m(input addr_t a, input reg8_t d);
        host.wr(a, d);
        if (ce === 1'b1 && a == 8'h33) mdl[a] = d;
        if (ce === 1'b1 && a == 8'h2f) mdl[a] = d & 8'hf8;
    endtask
    // events need five edges to latch and one more for the interrupt
    task automatic settle();
        repeat (6) @(negedge mclk);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        results();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst, ce} = 2'b11;
        {sys_event_raw, upper_event_raw, ch1_fault_raw, ch2_fault_any_raw, vbat_low_short_raw} = '0;
        {ch1_fault_mask, vbat_short_mask, upper_latch_clear} = 3'b000;
        void'($urandom(66887));
        mdl[8'h2f] = 8'hf8;
        mdl[8'h33] = 8'h30;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        // reset values and an unmapped place
        rd_chk(8'h33, 8'h30);
        rd_chk(8'h2f, 8'hf8);
        rd_chk(8'h34, 8'h00);
        rd_chk(8'h35, 8'h00);
        rd_chk(8'h36, 8'h00);
        rd_chk(8'h40, 8'h00);
        chk_reg(upper_mask_out, 8'h30, "mask out");
        chk_reg(sys_mask_out, 8'hf8, "system mask out");
        // each mask bit alone, then random patterns
        for (int i = 0; i < 12; i++) begin
            d = (i < 8) ? reg8_t'(8'h01 << i) : reg8_t'($urandom);
            wr_m(8'h33, d);
            rd_chk(8'h33, mdl[8'h33]);
        end
        // reserved bits written as zero, ignored writes, frozen clock enable
        wr_m(8'h2f, 8'h50);
        rd_chk(8'h2f, mdl[8'h2f]);
        wr_m(8'h34, 8'hf8);
        rd_chk(8'h34, 8'h00);
        ce = 1'b0;
        wr_m(8'h33, ~mdl[8'h33]);
        ce = 1'b1;
        rd_chk(8'h33, mdl[8'h33]);
        // system events masked, then unmasked, each cleared by reads
        for (int i = 0; i < 5; i++) begin
            e = reg8_t'(8'h08 << i);
            wr_m(8'h2f, 8'hf8);
            sys_event_raw = 5'(1 << i);
            settle();
            chk_bit(irq, 1'b0, "masked irq");
            sys_event_raw = '0;
            settle();
            rd_chk(8'h34, e);
            rd_chk(8'h34, 8'h00);
            wr_m(8'h2f, 8'h00);
            sys_event_raw = 5'(1 << i);
            settle();
            chk_bit(irq, 1'b1, "irq");
            rd_chk(8'h34, e);
            sys_event_raw = '0;
            settle();
            rd_chk(8'h34, e);
            rd_chk(8'h34, 8'h00);
        end
        // channel one faults, summary follows the latch
        for (int i = 0; i < 8; i++) begin
            ch1_fault_mask = i[0];
            ch1_fault_raw = 8'(1 << i);
            settle();
            chk_bit(irq, !i[0], "channel irq");
            rd_chk(8'h35, 8'h80);
            ch1_fault_raw = '0;
            settle();
            rd_chk(8'h36, 8'(1 << i));
            rd_chk(8'h35, 8'h00);
            rd_chk(8'h36, 8'h00);
        end
        // channel two and battery short in the summary
        {ch2_fault_any_raw, vbat_low_short_raw, vbat_short_mask} = 3'b111;
        settle();
        chk_bit(irq, 1'b0, "battery masked irq");
        vbat_short_mask = 1'b0;
        repeat (2) @(negedge mclk);
        chk_bit(irq, 1'b1, "battery irq");
        rd_chk(8'h35, 8'h48);
        {ch2_fault_any_raw, vbat_low_short_raw} = 2'b00;
        settle();
        rd_chk(8'h35, 8'h08);
        rd_chk(8'h35, 8'h00);
        // random upper events against random masks
        for (int k = 0; k < 6; k++) begin
            d = reg8_t'($urandom);
            e = reg8_t'($urandom);
            wr_m(8'h33, d);
            upper_event_raw = e;
            settle();
            chk_reg(upper_event_latched, e, "upper latch");
            chk_bit(irq, |(e & ~mdl[8'h33]), "upper irq");
            upper_event_raw = '0;
            settle();
            upper_latch_clear = 1'b1;
            @(negedge mclk);
            upper_latch_clear = 1'b0;
            settle();
            chk_reg(upper_event_latched, 8'h00, "upper clear");
        end
        results();
    end
endmodule
`default_nettype wire
